// ===== common/ibt_pkg.sv
// package: register map, field positions and timing constants
package ibt_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_FINE_NS = 1000;
  localparam int unsigned TICK_FINE_CYCLES = TICK_FINE_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_COARSE_MULT = 16;
  localparam logic [7:0] ADDR_WBLK = 8'h79;
  localparam logic [7:0] ADDR_WADDR = 8'h7A;
  localparam logic [7:0] ADDR_WDATA = 8'h7B;
  localparam logic [7:0] ADDR_RBLK = 8'h7C;
  localparam logic [7:0] ADDR_RADDR = 8'h7D;
  localparam logic [7:0] ADDR_RRES = 8'h7E;
  localparam logic [7:0] ADDR_SYNC_HI = 8'h7F;
  localparam logic [7:0] BLK_FIRST = 8'h00;
  localparam logic [7:0] BLK_SECOND = 8'h28;
  localparam logic [7:0] EXT_TMST_CFG = 8'h00;
  localparam logic [7:0] EXT_FIFO_CFG5 = 8'h01;
  localparam logic [7:0] EXT_SYNC_LO = 8'h02;
  localparam logic [7:0] EXT_SYNC_HI = 8'h03;
  localparam logic [7:0] TMST_CFG_RESET = 8'h02;
  localparam logic [7:0] FIFO_CFG5_RESET = 8'h20;
  localparam logic [7:0] TMST_CFG_MASK = 8'h1F;
  localparam int unsigned BIT_STAMP_EN = 0;
  localparam int unsigned BIT_SYNC_EN = 1;
  localparam int unsigned BIT_DELTA_EN = 2;
  localparam int unsigned BIT_RES = 3;
  localparam int unsigned BIT_REPORT_SEL = 4;
  localparam int unsigned BIT_FIFO_SYNC_EN = 2;
  typedef enum logic [1:0] {
    HST_IDLE = 2'b00,
    HST_SEL = 2'b01,
    HST_ADDR = 2'b11,
    HST_DATA = 2'b10
  } ibt_hst_state_t;
endpackage

// ===== common/ibt_if.sv
// interface: 8-bit parallel register port between host and device
`timescale 1ns/1ps
interface ibt_if;
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport dev (input wr_en, input rd_en, input addr, input wdata,
    output rdata);
  modport hst (output wr_en, output rd_en, output addr, output wdata,
    input rdata);
endinterface

// ===== design/ibt_device.sv
// device end: indirect bank port and timestamp configuration
// What this block and the host do
// [RULE1] write-address byte picks indirect write target
// [RULE2] write-data byte lands in selected bank register
// [RULE3] read block select chooses read bank
// [RULE4] read-address byte picks indirect read source
// [RULE5] read-result byte shows addressed bank register
// [RULE6] report bit 0: sync delta to tick
// [RULE7] report bit 1: absolute unless sync seen
// [RULE8] resolution bit: 1 us or 16 us
// [RULE9] delta enable: stamp counts since last tick
// [RULE10] sync stamp enable, reset high, gates capture
// [RULE11] fifo stamp needs both sync enables
// [RULE12] stamp enable turns timestamp function on
// [RULE13] write block select chooses write bank
// [RULE14] fifo bit allows sync stamp replacement
// [RULE15] host sets select/address before data/result
`timescale 1ns/1ps
module ibt_device
  import ibt_pkg::*;
#(
  parameter int unsigned STAMP_W = 16
)(
  input wire logic sys_clk,
  input wire logic srst,
  ibt_if.dev bus,
  input wire logic frame_sync_input,
  input wire logic output_data_rate_tick,
  output logic [STAMP_W-1:0] stamp_value,
  output logic [STAMP_W-1:0] fifo_stamp,
  output logic fifo_stamp_is_sync
);
  import ibt_pkg::*;

  typedef struct packed {
    logic [7:0] wblk;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic [7:0] rblk;
    logic [7:0] raddr;
    logic [7:0] rres;
    logic [7:0] tmst_cfg;
    logic [7:0] fifo_cfg5;
    logic [6:0] pre;
    logic [3:0] coarse;
    logic [STAMP_W-1:0] free_cnt;
    logic [STAMP_W-1:0] since_tick;
    logic [STAMP_W-1:0] since_sync;
    logic sync_pending;
    logic [STAMP_W-1:0] sync_stamp;
    logic [STAMP_W-1:0] stamp_out;
    logic [STAMP_W-1:0] fifo_out;
    logic fifo_sync;
    logic [7:0] rdata;
  } ibt_dev_state_t;

  localparam logic [6:0] PRE_LAST = 7'(TICK_FINE_CYCLES - 1);
  localparam logic [3:0] COARSE_LAST = 4'(TICK_COARSE_MULT - 1);

  ibt_dev_state_t s_reg;
  ibt_dev_state_t s_next;

  function automatic logic [7:0] ext_read(input ibt_dev_state_t s,
                                          input logic [7:0] blk,
                                          input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (blk == BLK_FIRST)
    begin
      case (a)
        EXT_TMST_CFG: v = s.tmst_cfg;
        EXT_FIFO_CFG5: v = s.fifo_cfg5;
        EXT_SYNC_LO: v = s.sync_stamp[7:0];
        EXT_SYNC_HI: v = s.sync_stamp[15:8];
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction

  logic tick_now;
  logic en;
  logic sync_cap;
  logic [STAMP_W-1:0] one;

  always_comb
  begin
    s_next = s_reg;
    one = STAMP_W'(1);
    en = s_reg.tmst_cfg[BIT_STAMP_EN]; // RULE12
    sync_cap = en && s_reg.tmst_cfg[BIT_SYNC_EN]; // RULE10
    tick_now = 1'b0;
    // register writes
    if (bus.wr_en)
    begin
      case (bus.addr)
        ADDR_WBLK: s_next.wblk = bus.wdata; // RULE13
        ADDR_WADDR: s_next.waddr = bus.wdata; // RULE1
        ADDR_RBLK: s_next.rblk = bus.wdata; // RULE3
        ADDR_RADDR: s_next.raddr = bus.wdata; // RULE4
        ADDR_RRES: s_next.rres = bus.wdata;
        ADDR_WDATA:
        begin
          s_next.wdata = bus.wdata; // RULE2
          if (s_reg.wblk == BLK_FIRST)
          begin
            if (s_reg.waddr == EXT_TMST_CFG)
              s_next.tmst_cfg = bus.wdata & TMST_CFG_MASK; // RULE2
            else if (s_reg.waddr == EXT_FIFO_CFG5)
              s_next.fifo_cfg5 = bus.wdata; // RULE2
          end
        end
        default: ;
      endcase
    end
    // prescaler: 1 us fine tick, 16 us coarse tick
    if (!en)
    begin
      s_next.pre = '0;
      s_next.coarse = '0;
    end
    else if (s_reg.pre == PRE_LAST)
    begin
      s_next.pre = '0;
      s_next.coarse = s_reg.coarse + 4'h1;
      tick_now = !s_reg.tmst_cfg[BIT_RES] ||
                 (s_reg.coarse == COARSE_LAST); // RULE8
    end
    else
      s_next.pre = s_reg.pre + 7'h01;
    if (tick_now)
    begin
      s_next.free_cnt = s_reg.free_cnt + one;
      s_next.since_tick = s_reg.since_tick + one;
      if (s_reg.sync_pending)
        s_next.since_sync = s_reg.since_sync + one;
    end
    if (en && output_data_rate_tick)
    begin
      s_next.since_tick = '0; // RULE9
      s_next.stamp_out = s_reg.tmst_cfg[BIT_DELTA_EN] ?
                         s_reg.since_tick : s_reg.free_cnt; // RULE9
      s_next.fifo_sync = 1'b0;
      s_next.fifo_out = s_next.stamp_out;
      if (s_reg.sync_pending)
      begin
        s_next.sync_stamp = s_reg.since_sync; // RULE6
        s_next.sync_pending = 1'b0;
        if (s_reg.tmst_cfg[BIT_SYNC_EN] &&
            s_reg.fifo_cfg5[BIT_FIFO_SYNC_EN])
        begin
          s_next.fifo_out = s_reg.since_sync; // RULE11 RULE14
          s_next.fifo_sync = 1'b1;
        end
      end
      else if (s_reg.tmst_cfg[BIT_REPORT_SEL])
        s_next.sync_stamp = s_reg.free_cnt; // RULE7
    end
    // a new sync event wins over the tick's clear
    if (sync_cap && frame_sync_input)
    begin
      s_next.sync_pending = 1'b1; // RULE10
      s_next.since_sync = '0;
    end
    // read data
    case (bus.addr)
      ADDR_WBLK: s_next.rdata = s_reg.wblk;
      ADDR_WADDR: s_next.rdata = s_reg.waddr;
      ADDR_WDATA: s_next.rdata = s_reg.wdata;
      ADDR_RBLK: s_next.rdata = s_reg.rblk;
      ADDR_RADDR: s_next.rdata = s_reg.raddr;
      ADDR_RRES:
        s_next.rdata = ext_read(s_reg, s_reg.rblk, s_reg.raddr); // RULE5
      default: s_next.rdata = 8'h00;
    endcase
    s_next.rres = ext_read(s_reg, s_reg.rblk, s_reg.raddr); // RULE5
    if (srst)
    begin
      s_next = '0;
      s_next.tmst_cfg = TMST_CFG_RESET;
      s_next.fifo_cfg5 = FIFO_CFG5_RESET;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    s_reg <= s_next;
  end

  assign bus.rdata = s_reg.rdata;
  assign stamp_value = s_reg.stamp_out;
  assign fifo_stamp = s_reg.fifo_out;
  assign fifo_stamp_is_sync = s_reg.fifo_sync;
endmodule

// ===== design/ibt_host.sv
// host end: sequences indirect bank writes and reads
`timescale 1ns/1ps
module ibt_host
  import ibt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  ibt_if.hst bus,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_block,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_data,
  output logic req_ready,
  output logic [7:0] rsp_data,
  output logic rsp_valid
);
  import ibt_pkg::*;

  typedef struct packed {
    ibt_hst_state_t st;
    logic write;
    logic [7:0] blk;
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] rsp;
    logic rsp_v;
    logic wr_en;
    logic [7:0] baddr;
    logic [7:0] bdata;
    logic rd_wait;
  } ibt_hst_regs_t;

  ibt_hst_regs_t h_reg;
  ibt_hst_regs_t h_next;

  always_comb
  begin
    h_next = h_reg;
    h_next.rsp_v = 1'b0;
    h_next.wr_en = 1'b0;
    case (h_reg.st)
      HST_IDLE:
      begin
        if (req_valid)
        begin
          h_next.write = req_write;
          h_next.blk = req_block;
          h_next.addr = req_addr;
          h_next.data = req_data;
          h_next.st = HST_SEL;
        end
      end
      HST_SEL:
      begin
        h_next.wr_en = 1'b1;
        h_next.baddr = h_reg.write ? ADDR_WBLK : ADDR_RBLK; // RULE13 RULE3
        h_next.bdata = h_reg.blk;
        h_next.st = HST_ADDR;
      end
      HST_ADDR:
      begin
        h_next.wr_en = 1'b1;
        h_next.baddr = h_reg.write ? ADDR_WADDR : ADDR_RADDR; // RULE1 RULE4
        h_next.bdata = h_reg.addr;
        h_next.st = HST_DATA;
      end
      HST_DATA:
      begin
        if (h_reg.write)
        begin
          h_next.wr_en = 1'b1;
          h_next.baddr = ADDR_WDATA; // RULE2 RULE15
          h_next.bdata = h_reg.data;
          h_next.rsp_v = 1'b1;
          h_next.st = HST_IDLE;
        end
        else if (h_reg.baddr != ADDR_RRES)
          h_next.baddr = ADDR_RRES;
        else if (!h_reg.rd_wait)
          h_next.rd_wait = 1'b1; // rdata lags the result address a cycle
        else
        begin
          h_next.rsp = bus.rdata; // RULE5 RULE15
          h_next.rsp_v = 1'b1;
          h_next.rd_wait = 1'b0;
          h_next.st = HST_IDLE;
        end
      end
      default: h_next.st = HST_IDLE;
    endcase
    if (srst)
      h_next = '0;
  end

  always_ff @(posedge sys_clk)
  begin
    h_reg <= h_next;
  end

  assign bus.wr_en = h_reg.wr_en;
  assign bus.rd_en = 1'b0;
  assign bus.addr = h_reg.baddr;
  assign bus.wdata = h_reg.bdata;
  assign req_ready = (h_reg.st == HST_IDLE);
  assign rsp_data = h_reg.rsp;
  assign rsp_valid = h_reg.rsp_v;
endmodule

// ===== verif/ibt_props.sv
// checker: sequencing and read-back relations on the register port
`timescale 1ns/1ps
module ibt_props
  import ibt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_wblk_then_waddr: assert property (wr_en && addr == ADDR_WBLK
    |=> wr_en && addr == ADDR_WADDR) else $error("write address missing");
  a_waddr_then_wdata: assert property (wr_en && addr == ADDR_WADDR
    |=> wr_en && addr == ADDR_WDATA) else $error("write data missing");
  a_wdata_after_sel: assert property (wr_en && addr == ADDR_WDATA
    |-> $past(addr, 2) == ADDR_WBLK && $past(addr) == ADDR_WADDR)
    else $error("data written before select");
  a_rblk_then_raddr: assert property (wr_en && addr == ADDR_RBLK
    |=> wr_en && addr == ADDR_RADDR) else $error("read address missing");
  a_raddr_then_result: assert property (wr_en && addr == ADDR_RADDR
    |=> !wr_en && addr == ADDR_RRES) else $error("result not fetched");
  a_result_after_raddr: assert property (!wr_en && addr == ADDR_RRES
    |-> $past(addr) == ADDR_RRES || $past(addr) == ADDR_RADDR)
    else $error("result read out of order");
  a_second_bank_zero: assert property (
    (wr_en && addr == ADDR_RBLK && wdata == BLK_SECOND) ##1
    (wr_en && addr == ADDR_RADDR) ##1 (addr == ADDR_RRES)
    |=> rdata == 8'h00) else $error("empty bank read not zero");
  a_cfg_reserved_zero: assert property (
    (wr_en && addr == ADDR_RBLK && wdata == BLK_FIRST) ##1
    (wr_en && addr == ADDR_RADDR && wdata == EXT_TMST_CFG) ##1
    (addr == ADDR_RRES) |=> rdata[7:5] == 3'b000)
    else $error("reserved config bits set");
endmodule

// ===== verif/indirect_bank_access_timestamp_cfg_tb.sv
// testbench: host and device ends joined through the register port
`timescale 1ns/1ps
module indirect_bank_access_timestamp_cfg_tb;
  import ibt_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic frame_sync_input = 1'b0;
  logic output_data_rate_tick = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [7:0] req_block = 8'h00;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_data = 8'h00;
  logic req_ready;
  logic [7:0] rsp_data;
  logic rsp_valid;
  logic [15:0] stamp_value;
  logic [15:0] fifo_stamp;
  logic fifo_stamp_is_sync;
  int n_fail = 0;
  int checks = 0;
  ibt_if bus ();
  ibt_device u_ibt_device (.sys_clk(sys_clk), .srst(srst), .bus(bus),
    .frame_sync_input(frame_sync_input),
    .output_data_rate_tick(output_data_rate_tick),
    .stamp_value(stamp_value), .fifo_stamp(fifo_stamp),
    .fifo_stamp_is_sync(fifo_stamp_is_sync));
  ibt_host u_ibt_host (.sys_clk(sys_clk), .srst(srst), .bus(bus),
    .req_valid(req_valid), .req_write(req_write), .req_block(req_block),
    .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready),
    .rsp_data(rsp_data), .rsp_valid(rsp_valid));
  ibt_props u_ibt_props (.sys_clk(sys_clk), .srst(srst), .wr_en(bus.wr_en),
    .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata));
  always #5 sys_clk = ~sys_clk;
  task end_sim;
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task rng(input string n, input int lo, input int hi, input logic [15:0] g);
    checks++;
    if ($isunknown(g) || g < lo || g > hi)
    begin
      n_fail++;
      $display("[FAIL] %s expected %0d..%0d seen %h", n, lo, hi, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // one host request, waits for its response pulse
  task op(input logic w, input logic [7:0] b, input logic [7:0] a,
    input logic [7:0] d);
    int i;
    @(posedge sys_clk) #1;
    req_valid = 1'b1;
    req_write = w;
    req_block = b;
    req_addr = a;
    req_data = d;
    for (i = 0; i < 50 && req_ready !== 1'b1; i++) cyc(1);
    if (i == 50)
    begin
      n_fail++;
      $display("[FAIL] req_ready expected 1 seen timeout");
      end_sim();
    end
    cyc(1);
    req_valid = 1'b0;
    for (i = 0; i < 20 && rsp_valid !== 1'b1; i++) cyc(1);
    if (i == 20)
    begin
      n_fail++;
      $display("[FAIL] rsp_valid expected 1 seen timeout");
      end_sim();
    end
  endtask
  task rd(input string n, input logic [7:0] b, input logic [7:0] a,
    input logic [7:0] e);
    op(1'b0, b, a, 8'h00);
    rng(n, e, e, {8'h00, rsp_data});
  endtask
  task tick;
    output_data_rate_tick = 1'b1;
    cyc(1);
    output_data_rate_tick = 1'b0;
  endtask
  task t_regs;
    rd("cfg reset", BLK_FIRST, EXT_TMST_CFG, TMST_CFG_RESET);
    rd("fifo reset", BLK_FIRST, EXT_FIFO_CFG5, FIFO_CFG5_RESET);
    op(1'b1, BLK_FIRST, EXT_TMST_CFG, 8'hFF);
    rd("cfg back", BLK_FIRST, EXT_TMST_CFG, TMST_CFG_MASK);
    op(1'b1, BLK_SECOND, EXT_TMST_CFG, 8'h55);
    rd("cfg kept", BLK_FIRST, EXT_TMST_CFG, TMST_CFG_MASK);
    rd("bank two", BLK_SECOND, EXT_TMST_CFG, 8'h00);
    $display("test regs done");
  endtask
  // ticks a fixed gap apart, delta stamp read as elapsed units
  task t_stamp(input logic [7:0] c, input int gap, input int lo,
    input int hi);
    op(1'b1, BLK_FIRST, EXT_TMST_CFG, c);
    cyc(1);
    tick();
    cyc(gap - 1);
    tick();
    cyc(2);
    rng("stamp", lo, hi, stamp_value);
    $display("test stamp %h done", c);
  endtask
  task t_sync;
    logic [7:0] cf[3] = '{8'h03, 8'h01, 8'h03};
    logic [7:0] f5[3] = '{8'h24, 8'h24, 8'h20};
    int ex[3] = '{1, 0, 0};
    for (int k = 0; k < 3; k++)
    begin
      op(1'b1, BLK_FIRST, EXT_TMST_CFG, cf[k]);
      op(1'b1, BLK_FIRST, EXT_FIFO_CFG5, f5[k]);
      tick();
      frame_sync_input = 1'b1;
      cyc(1);
      frame_sync_input = 1'b0;
      cyc(499);
      tick();
      cyc(2);
      rng("is sync", ex[k], ex[k], {15'h0000, fifo_stamp_is_sync});
    end
    op(1'b1, BLK_FIRST, EXT_FIFO_CFG5, 8'h24);
    op(1'b1, BLK_FIRST, EXT_TMST_CFG, 8'h03);
    tick();
    frame_sync_input = 1'b1;
    cyc(1);
    frame_sync_input = 1'b0;
    cyc(499);
    tick();
    cyc(2);
    rng("fifo stamp", 4, 5, fifo_stamp);
    op(1'b0, BLK_FIRST, EXT_SYNC_LO, 8'h00);
    rng("sync low", 4, 5, {8'h00, rsp_data});
    $display("test sync done");
  endtask
  // report bit set, no sync: two latched absolute stamps ~950 cycles apart
  task t_abs;
    logic [7:0] a;
    op(1'b1, BLK_FIRST, EXT_TMST_CFG, 8'h13);
    cyc(1);
    tick();
    op(1'b0, BLK_FIRST, EXT_SYNC_LO, 8'h00);
    a = rsp_data;
    cyc(940);
    tick();
    op(1'b0, BLK_FIRST, EXT_SYNC_LO, 8'h00);
    rng("abs gap", 9, 10, {8'h00, 8'(rsp_data - a)});
    $display("test abs done");
  endtask
  initial
  begin
    cyc(20);
    srst = 1'b0;
    t_regs();
    t_stamp(8'h04, 1000, 0, 0);
    t_stamp(8'h05, 1000, 9, 10);
    t_stamp(8'h0D, 3200, 1, 2);
    t_sync();
    t_abs();
    end_sim();
  end
endmodule
